// ---- srcc_clkdiv.sv ----
// Even-ratio divider for the reference clock output.
// Assumes ref_rise is a one-cycle pulse per reference rising edge on the same clock.
module srcc_clkdiv (
    input wire clk,
    input wire rst_n,
    input wire ref_rise,
    input wire [3:0] half,
    output logic div_out
);
    logic [3:0] cnt_r;
    logic [3:0] half_r;

    // The output toggles every half reference periods, so high and low are equal.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            half_r <= srcc_pkg::CKDIV_DEF;
            div_out <= 1'b0;
        end else if (half != half_r) begin
            // A new ratio restarts the count so no runt half period is stretched.
            cnt_r <= 4'h0;
            half_r <= half;
        end else if (ref_rise) begin
            if (cnt_r == half_r - 4'h1) begin
                cnt_r <= 4'h0;
                div_out <= ~div_out;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ---- srcc_device.sv ----
// Device end: serial load port, settings latches, reference selection and clock output.
// Assumes the host drives the pins of the interface; every pin is synchronised here.
// What this block does
// - Divide word holds integer plus fraction over 4096.
// - Crystal oscillator runs while its disable bit is low.
// - Oscillator on by default, off while chip-enable low.
// - External reference used when oscillator disabled.
// - Signed 11-bit correction adds in 2^-15 steps.
// - Clock output is reference over even ratio 2-30.
// - Ratio taken from bits 19 to 22.
// - Ratio defaults to sixteen.
// - Clock output driven only while buffer enable high.
// - Two varactor trim bits are stored and presented.
// - Host should avoid bias codes 0, E, F.
// - Chip-enable low clears every setting.
// - Host writes only when powered and regulator ready.
// - Host waits for start-up or watches supply flag.
// - Diagnostic output shows supply ready by default.
// - Words shift in MSB first, two LSBs select.
// - Load strobe rise copies word into selected latch.
//
// Chosen here: the address-and-strobe port and the address map.
module srcc_device (
    input wire CLOCK,
    input wire RSTN,
    srcc_if.dev LINK,
    output logic XTAL_OSC_RUN,
    output logic [23:0] SYNTH_DIVIDE_WORD,
    output logic [1:0] VARACTOR_TRIM,
    output logic [3:0] VCO_BIAS,
    output logic SUPPLY_OK,
    output logic [31:0] MODULATION_WORD
);
    // Pin order in the synchroniser: chip enable, serial clock, data, load, reference.
    localparam int P_CE = 4;
    localparam int P_SCK = 3;
    localparam int P_SDA = 2;
    localparam int P_LD = 1;
    localparam int P_REF = 0;

    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic sck_prev_r;
    logic ld_prev_r;
    logic ce_s;
    logic sck_rise;
    logic ld_rise;
    logic settings_rst_n;

    logic [11:0] reg_cnt_r;
    logic supply_ok_r;
    logic [31:0] shift_r;

    logic [10:0] corr_r;
    logic [3:0] ckdiv_r;
    logic [1:0] var_r;
    logic xod_r;
    logic [11:0] frac_r;
    logic [7:0] nint_r;
    logic [31:0] mod_r;
    logic bufen_r;
    logic [3:0] vb_r;
    logic [3:0] mux_r;

    logic xtal_run;
    logic [3:0] xtal_cnt_r;
    logic xtal_lvl_r;
    logic ref_lvl;
    logic ref_prev_r;
    logic ref_rise;
    logic [3:0] ckdiv_eff;
    logic div_out;
    logic diag_nxt;

    // The first stage is read only by the second.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
        end else begin
            meta_r <= {LINK.chip_enable, LINK.serial_clock, LINK.serial_data,
                       LINK.load_strobe, LINK.ref_input_pin};
            sync_r <= meta_r;
        end
    end

    assign ce_s = sync_r[P_CE];
    assign settings_rst_n = RSTN & ce_s;
    assign sck_rise = sync_r[P_SCK] & ~sck_prev_r;
    assign ld_rise = sync_r[P_LD] & ~ld_prev_r;

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            sck_prev_r <= 1'b0;
            ld_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sync_r[P_SCK];
            ld_prev_r <= sync_r[P_LD];
        end
    end

    // Regulator model: ready a fixed start-up time after chip enable rises.
    always_ff @(posedge CLOCK) begin
        if (!settings_rst_n) begin
            reg_cnt_r <= 12'h000;
            supply_ok_r <= 1'b0;
        end else if (!supply_ok_r) begin
            reg_cnt_r <= reg_cnt_r + 12'h001;
            supply_ok_r <= (reg_cnt_r == srcc_pkg::REG_UP_CYCLES - 12'h001);
        end
    end

    // The port is dead until the regulator is up; bits sent earlier are lost.
    always_ff @(posedge CLOCK) begin
        if (!settings_rst_n || !supply_ok_r) begin
            shift_r <= 32'h00000000;
        end else if (sck_rise) begin
            shift_r <= {shift_r[30:0], sync_r[P_SDA]};
        end
    end

    // Latches return to power-up values whenever chip enable is low.
    always_ff @(posedge CLOCK) begin
        if (!settings_rst_n) begin
            corr_r <= 11'h000;
            ckdiv_r <= srcc_pkg::CKDIV_DEF;
            var_r <= srcc_pkg::VAR_DEF;
            xod_r <= srcc_pkg::XOD_DEF;
            frac_r <= 12'h000;
            nint_r <= 8'h00;
            mod_r <= 32'h00000000;
            bufen_r <= srcc_pkg::BUFEN_DEF;
            vb_r <= srcc_pkg::VB_DEF;
            mux_r <= srcc_pkg::MUX_DEF;
        end else if (ld_rise && supply_ok_r) begin
            // The control bits choose one of four latches.
            case (shift_r[srcc_pkg::SEL_W-1:0])
                srcc_pkg::SEL_REF: begin
                    corr_r <= shift_r[srcc_pkg::CORR_LSB +: srcc_pkg::CORR_W];
                    ckdiv_r <= shift_r[srcc_pkg::CKDIV_LSB +: srcc_pkg::CKDIV_W];
                    var_r <= shift_r[srcc_pkg::VAR_LSB +: srcc_pkg::VAR_W];
                    xod_r <= shift_r[srcc_pkg::XOD_BIT];
                end
                srcc_pkg::SEL_NDIV: begin
                    frac_r <= shift_r[srcc_pkg::FRAC_LSB +: srcc_pkg::FRAC_W];
                    nint_r <= shift_r[srcc_pkg::NINT_LSB +: srcc_pkg::NINT_W];
                end
                srcc_pkg::SEL_MOD: begin
                    mod_r <= shift_r;
                end
                srcc_pkg::SEL_FUNC: begin
                    bufen_r <= shift_r[srcc_pkg::BUFEN_BIT];
                    vb_r <= shift_r[srcc_pkg::VB_LSB +: srcc_pkg::VB_W];
                    mux_r <= shift_r[srcc_pkg::MUX_LSB +: srcc_pkg::MUX_W];
                end
                default: begin
                    mod_r <= mod_r;
                end
            endcase
        end
    end

    // The oscillator runs only with chip enable high and its disable bit low.
    assign xtal_run = ce_s & ~xod_r;

    // Crystal model: a free square wave derived from the system clock while enabled.
    always_ff @(posedge CLOCK) begin
        if (!RSTN || !xtal_run) begin
            xtal_cnt_r <= 4'h0;
            xtal_lvl_r <= 1'b0;
        end else if (xtal_cnt_r == srcc_pkg::XTAL_HALF - 4'h1) begin
            xtal_cnt_r <= 4'h0;
            xtal_lvl_r <= ~xtal_lvl_r;
        end else begin
            xtal_cnt_r <= xtal_cnt_r + 4'h1;
        end
    end

    // With the oscillator off the square wave on the reference pin is the reference.
    assign ref_lvl = xtal_run ? xtal_lvl_r : (ce_s & sync_r[P_REF]);
    assign ref_rise = ref_lvl & ~ref_prev_r;

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ref_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_lvl;
        end
    end

    // A zero ratio field cannot give an even ratio, so it is run as divide by two.
    assign ckdiv_eff = (ckdiv_r == 4'h0) ? srcc_pkg::CKDIV_MIN : ckdiv_r;

    srcc_clkdiv u_clkdiv (
        .clk(CLOCK),
        .rst_n(settings_rst_n),
        .ref_rise(ref_rise),
        .half(ckdiv_eff),
        .div_out(div_out)
    );

    // Diagnostic selection; unused codes read low.
    always_comb begin
        case (mux_r)
            srcc_pkg::MUX_SUPPLY_OK: diag_nxt = supply_ok_r;
            srcc_pkg::MUX_XTAL_RUN: diag_nxt = xtal_run;
            default: diag_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            LINK.diag_mux_output <= 1'b0;
            LINK.divided_ref_output <= 1'b0;
            LINK.divided_ref_oe <= 1'b0;
        end else begin
            LINK.diag_mux_output <= diag_nxt;
            LINK.divided_ref_output <= div_out;
            LINK.divided_ref_oe <= bufen_r & ce_s;
        end
    end

    // Divide word in 2^-15 units: integer, fraction scaled by eight, signed correction.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            SYNTH_DIVIDE_WORD <= 24'h000000;
            XTAL_OSC_RUN <= 1'b0;
            VARACTOR_TRIM <= 2'h0;
            VCO_BIAS <= 4'h0;
            SUPPLY_OK <= 1'b0;
            MODULATION_WORD <= 32'h00000000;
        end else begin
            SYNTH_DIVIDE_WORD <= {1'b0, nint_r, 15'h0000} + {9'h000, frac_r, 3'h0}
                                 + {{13{corr_r[10]}}, corr_r};
            XTAL_OSC_RUN <= xtal_run;
            VARACTOR_TRIM <= var_r;
            VCO_BIAS <= vb_r;
            SUPPLY_OK <= supply_ok_r;
            MODULATION_WORD <= mod_r;
        end
    end
endmodule

// ---- srcc_host.sv ----
// Host end: takes words from a register port and shifts them out over the 3-wire port.
// Assumes the device end syncs every pin, so each pin level is held at least two cycles.
module srcc_host (
    input wire CLOCK,
    input wire RSTN,
    srcc_if.host LINK,
    input wire [1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output logic [31:0] RDATA
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_LOW = 6'h04,
        ST_HIGH = 6'h08,
        ST_LOAD = 6'h10,
        ST_GAP = 6'h20
    } srcc_hstate_type;

    srcc_hstate_type state_r;
    logic ce_r;
    logic ext_r;
    logic pending_r;
    logic [31:0] tx_r;
    logic [31:0] shreg_r;
    logic [4:0] bitcnt_r;
    logic [3:0] tmr_r;
    logic warn_r;
    logic ready_r;
    logic diag_meta_r;
    logic diag_sync_r;
    logic [3:0] ref_cnt_r;
    logic tx_take;
    logic half_done;

    assign tx_take = WR && (ADDR == srcc_pkg::H_TX) && !pending_r;
    assign half_done = (tmr_r == srcc_pkg::SCLK_HALF - 4'h1);

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ce_r <= 1'b0;
            ext_r <= 1'b0;
            tx_r <= 32'h00000000;
        end else begin
            if (WR && ADDR == srcc_pkg::H_CTRL) begin
                ce_r <= WDATA[srcc_pkg::CTRL_CE_BIT];
                ext_r <= WDATA[srcc_pkg::CTRL_EXT_BIT];
            end
            if (tx_take) begin
                tx_r <= WDATA;
            end
        end
    end

    // Flags a function word with a bias code outside the safe set; a status write clears it.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            warn_r <= 1'b0;
        end else if (tx_take && WDATA[srcc_pkg::SEL_W-1:0] == srcc_pkg::SEL_FUNC
                     && srcc_pkg::srcc_bias_bad(WDATA[srcc_pkg::VB_LSB +: srcc_pkg::VB_W])) begin
            warn_r <= 1'b1;
        end else if (WR && ADDR == srcc_pkg::H_STAT) begin
            warn_r <= 1'b0;
        end
    end

    // Ready is remembered, because later diagnostic codes may hide the flag.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            diag_meta_r <= 1'b0;
            diag_sync_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            diag_meta_r <= LINK.diag_mux_output;
            diag_sync_r <= diag_meta_r;
            ready_r <= ce_r & (ready_r | diag_sync_r);
        end
    end

    // Square reference for the device while external reference is chosen.
    always_ff @(posedge CLOCK) begin
        if (!RSTN || !ext_r) begin
            ref_cnt_r <= 4'h0;
            LINK.ref_input_pin <= 1'b0;
        end else if (ref_cnt_r == srcc_pkg::EXT_REF_HALF - 4'h1) begin
            ref_cnt_r <= 4'h0;
            LINK.ref_input_pin <= ~LINK.ref_input_pin;
        end else begin
            ref_cnt_r <= ref_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            LINK.chip_enable <= 1'b0;
        end else begin
            LINK.chip_enable <= ce_r;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state_r <= ST_IDLE;
            pending_r <= 1'b0;
            shreg_r <= 32'h00000000;
            bitcnt_r <= 5'h00;
            tmr_r <= 4'h0;
            LINK.serial_clock <= 1'b0;
            LINK.serial_data <= 1'b0;
            LINK.load_strobe <= 1'b0;
        end else begin
            if (tx_take) begin
                pending_r <= 1'b1;
            end
            tmr_r <= half_done ? 4'h0 : tmr_r + 4'h1;
            case (state_r)
                ST_IDLE: begin
                    tmr_r <= 4'h0;
                    if (pending_r && ce_r) begin
                        state_r <= ST_WAIT;
                    end
                end
                // No bit leaves before chip enable is high and the regulator is ready.
                ST_WAIT: begin
                    tmr_r <= 4'h0;
                    if (!ce_r) begin
                        state_r <= ST_IDLE;
                    end else if (ready_r) begin
                        shreg_r <= tx_r;
                        bitcnt_r <= 5'h1F;
                        LINK.serial_data <= tx_r[31];
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (half_done) begin
                        LINK.serial_clock <= 1'b1;
                        state_r <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (half_done) begin
                        LINK.serial_clock <= 1'b0;
                        if (bitcnt_r == 5'h00) begin
                            LINK.load_strobe <= 1'b1;
                            state_r <= ST_LOAD;
                        end else begin
                            bitcnt_r <= bitcnt_r - 5'h01;
                            shreg_r <= {shreg_r[30:0], 1'b0};
                            LINK.serial_data <= shreg_r[30];
                            state_r <= ST_LOW;
                        end
                    end
                end
                ST_LOAD: begin
                    if (half_done) begin
                        LINK.load_strobe <= 1'b0;
                        pending_r <= 1'b0;
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (half_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN || !RD) begin
            RDATA <= 32'h00000000;
        end else begin
            case (ADDR)
                srcc_pkg::H_CTRL: RDATA <= {30'h00000000, ext_r, ce_r};
                srcc_pkg::H_TX: RDATA <= tx_r;
                srcc_pkg::H_STAT: RDATA <= {29'h00000000, warn_r, ready_r, pending_r};
                default: RDATA <= 32'h00000000;
            endcase
        end
    end
endmodule

// ---- srcc_if.sv ----
// Pin bundle between the synthesizer control device and its host controller.
// Assumes both ends run on the same clock; the clock output line is resolved here.
interface srcc_if;
    logic chip_enable;
    logic serial_clock;
    logic serial_data;
    logic load_strobe;
    logic ref_input_pin;
    logic diag_mux_output;
    logic divided_ref_output;
    logic divided_ref_oe;
    logic divided_ref_line;

    // An undriven clock output line is read as low.
    assign divided_ref_line = divided_ref_oe & divided_ref_output;

    modport dev (
        input chip_enable,
        input serial_clock,
        input serial_data,
        input load_strobe,
        input ref_input_pin,
        output diag_mux_output,
        output divided_ref_output,
        output divided_ref_oe
    );
    modport host (
        output chip_enable,
        output serial_clock,
        output serial_data,
        output load_strobe,
        output ref_input_pin,
        input diag_mux_output,
        input divided_ref_line
    );
endinterface

// ---- srcc_monitor.sv ----
// Concurrent checks on the pins joining the host end to the device end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
module srcc_monitor (
    input wire CLOCK,
    input wire RSTN,
    input logic chip_enable,
    input logic serial_clock,
    input logic serial_data,
    input logic load_strobe,
    input logic ref_input_pin,
    input logic diag_mux_output,
    input logic divided_ref_output,
    input logic divided_ref_oe,
    input logic divided_ref_line
);
    // Cycles since chip enable rose; it saturates so a long run cannot wrap.
    logic [15:0] up_r;
    always_ff @(posedge CLOCK) begin
        if (!RSTN || !chip_enable) begin
            up_r <= 16'h0000;
        end else if (up_r != 16'hFFFF) begin
            up_r <= up_r + 16'h0001;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence s_load_pulse;
        load_strobe [*2] ##1 !load_strobe;
    endsequence
    sequence s_clk_high;
        serial_clock [*2] ##1 !serial_clock;
    endsequence
    chk_load_width: assert property ($rose(load_strobe) |-> s_load_pulse)
        else $error("load strobe width wrong");
    chk_clock_high: assert property ($rose(serial_clock) |-> s_clk_high)
        else $error("serial clock high time wrong");
    chk_data_held: assert property ($rose(serial_clock) |=> $stable(serial_data))
        else $error("serial data moved while clock high");
    // The flag of an earlier power-up may still drain through the pipeline for a few cycles.
    chk_supply_early: assert property (up_r > 16'h0008 && up_r < 16'h0F96 |-> !diag_mux_output)
        else $error("supply flag before start-up time");
    chk_supply_on: assert property (up_r == 16'h0FAA |-> diag_mux_output)
        else $error("supply flag missing after start-up");
    chk_shift_ready: assert property ($rose(serial_clock) |-> up_r >= 16'h0FA0)
        else $error("shift before regulator ready");
    chk_idle_off: assert property (!chip_enable |-> !serial_clock && !load_strobe)
        else $error("serial activity while powered down");
    chk_down_clears: assert property ($fell(chip_enable) |-> ##[1:8] !diag_mux_output && !divided_ref_oe)
        else $error("outputs not cleared by power down");
    chk_buffer_on: assert property ($rose(chip_enable) |-> ##[1:8] divided_ref_oe)
        else $error("clock buffer not on after power up");
    chk_divided_ref_output_steady: assert property (divided_ref_oe && $changed(divided_ref_output) |=> $stable(divided_ref_output))
        else $error("clock output toggled on consecutive cycles");
endmodule

// ---- srcc_pkg.sv ----
// Shared constants for the synthesizer reference clock control pair.
// Assumes both ends and the divider share one 40 MHz clock and include nothing else.
package srcc_pkg;
    localparam int CLOCK_MHZ = 40;
    // Regulator start-up time in ns, and the cycles it takes at the clock rate.
    localparam int REG_UP_TIME_NS = 100000;
    localparam int REG_UP_CYCLES_INT = (REG_UP_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [11:0] REG_UP_CYCLES = REG_UP_CYCLES_INT[11:0];

    // Control bits in the two least significant bits select the latch.
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_NDIV = 2'h1;
    localparam logic [1:0] SEL_MOD = 2'h2;
    localparam logic [1:0] SEL_FUNC = 2'h3;
    localparam int SEL_W = 2;
    localparam int WORD_W = 32;

    // Reference register word.
    localparam int CORR_LSB = 8;
    localparam int CORR_W = 11;
    localparam int CKDIV_LSB = 19;
    localparam int CKDIV_W = 4;
    localparam int VAR_LSB = 23;
    localparam int VAR_W = 2;
    localparam int XOD_BIT = 25;
    // Divide register word.
    localparam int FRAC_LSB = 2;
    localparam int FRAC_W = 12;
    localparam int NINT_LSB = 14;
    localparam int NINT_W = 8;
    // Function register word.
    localparam int BUFEN_BIT = 4;
    localparam int VB_LSB = 8;
    localparam int VB_W = 4;
    localparam int MUX_LSB = 12;
    localparam int MUX_W = 4;

    // Divide word is in units of one 2^15 part of the phase-detector rate.
    localparam int DIVW_W = 24;

    localparam logic [3:0] CKDIV_DEF = 4'h8;
    localparam logic [3:0] CKDIV_MIN = 4'h1;
    localparam logic BUFEN_DEF = 1'b1;
    localparam logic XOD_DEF = 1'b0;
    localparam logic [1:0] VAR_DEF = 2'h0;
    localparam logic [3:0] VB_DEF = 4'h4;
    localparam logic [3:0] MUX_SUPPLY_OK = 4'h0;
    localparam logic [3:0] MUX_XTAL_RUN = 4'h1;
    localparam logic [3:0] MUX_DEF = MUX_SUPPLY_OK;

    localparam logic [3:0] VB_BAD_LO = 4'h0;
    localparam logic [3:0] VB_BAD_HI1 = 4'hE;
    localparam logic [3:0] VB_BAD_HI2 = 4'hF;

    // Half periods, in clock cycles, of the crystal model and the host's clocks.
    localparam logic [3:0] XTAL_HALF = 4'h2;
    localparam logic [3:0] EXT_REF_HALF = 4'h3;
    localparam logic [3:0] SCLK_HALF = 4'h2;

    // Host register offsets.
    localparam logic [1:0] H_CTRL = 2'h0;
    localparam logic [1:0] H_TX = 2'h1;
    localparam logic [1:0] H_STAT = 2'h2;
    localparam int CTRL_CE_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;

    function automatic logic srcc_bias_bad(input logic [3:0] code);
        srcc_bias_bad = (code == VB_BAD_LO) || (code == VB_BAD_HI1) || (code == VB_BAD_HI2);
    endfunction
endpackage

// ---- tb_synth_reference_clock_control.sv ----
// Bench joining the host end to the device end; it drives the host register port.
// Assumes the package's crystal half period, external half period and start-up delay.
module tb_synth_reference_clock_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, mod_word, cap;
    logic xtal_run, supply_ok, sclk_q;
    logic [23:0] div_word;
    logic [1:0] var_trim;
    logic [3:0] vco_bias;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    srcc_if link();
    srcc_device u_srcc_device (.CLOCK(clock), .RSTN(rstn), .LINK(link), .XTAL_OSC_RUN(xtal_run),
        .SYNTH_DIVIDE_WORD(div_word), .VARACTOR_TRIM(var_trim), .VCO_BIAS(vco_bias),
        .SUPPLY_OK(supply_ok), .MODULATION_WORD(mod_word));
    srcc_host u_srcc_host (.CLOCK(clock), .RSTN(rstn), .LINK(link), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    srcc_monitor u_srcc_monitor (.CLOCK(clock), .RSTN(rstn), .chip_enable(link.chip_enable),
        .serial_clock(link.serial_clock), .serial_data(link.serial_data), .load_strobe(link.load_strobe),
        .ref_input_pin(link.ref_input_pin), .diag_mux_output(link.diag_mux_output),
        .divided_ref_output(link.divided_ref_output), .divided_ref_oe(link.divided_ref_oe),
        .divided_ref_line(link.divided_ref_line));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // The bench records the wire itself so bit order is judged apart from the device.
    always @(posedge clock) begin
        sclk_q <= link.serial_clock;
        if (link.serial_clock && !sclk_q) begin
            cap <= {cap[30:0], link.serial_data};
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_stat(input int b, input logic v, input int n);
        logic [31:0] s;
        for (int i = 0; i < n; i++) begin
            rd_reg(srcc_pkg::H_STAT, s);
            if (s[b] === v) break;
        end
        cmp(32'(s[b]), 32'(v));
    endtask
    task automatic send(input logic [31:0] w);
        wr_reg(srcc_pkg::H_TX, w);
        wait_stat(0, 1'b0, 150);
        repeat (8) @(posedge clock);
        cmp(cap, w);
    endtask
    // The first two toggles are skipped, since a ratio change restarts the count.
    task automatic meas(input int h);
        int n;
        logic last;
        last = link.divided_ref_line;
        for (int k = 0; k < 4; k++) begin
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (link.divided_ref_line === last && n < 300);
            last = link.divided_ref_line;
            if (k > 1) cmp(32'(n), 32'(h));
        end
    endtask
    task automatic t_power();
        logic [31:0] s;
        wr_reg(srcc_pkg::H_CTRL, 32'h1);
        meas(32);
        cmp(32'(xtal_run), 32'h1);
        wait_stat(1, 1'b1, 2200);
        cmp(32'(link.diag_mux_output), 32'h1);
        cmp(32'(supply_ok), 32'h1);
        wr_reg(2'h3, 32'hFFFFFFFF);
        rd_reg(2'h3, s);
        cmp(s, 32'h0);
        $display("power up test done");
    endtask
    task automatic t_words();
        for (int r = 1; r < 16; r += 14) begin
            send({6'h00, 1'b0, 2'h3, 4'(r), 11'h7DC, 6'h00, srcc_pkg::SEL_REF});
            meas(r * 4);
        end
        cmp(32'(var_trim), 32'h3);
        send({10'h000, 8'h12, 12'hFFF, srcc_pkg::SEL_NDIV});
        cmp(32'(div_word), 32'((24'h12 << 15) + (24'hFFF << 3) - 24'h24));
        send(32'hA5A5A5A6);
        cmp(mod_word, 32'hA5A5A5A6);
        $display("word test done");
    endtask
    task automatic t_func();
        logic [31:0] s;
        int hi;
        hi = 0;
        send({16'h0000, 4'h0, 4'hE, 3'h0, 1'b0, 2'h0, srcc_pkg::SEL_FUNC});
        cmp(32'(vco_bias), 32'hE);
        rd_reg(srcc_pkg::H_STAT, s);
        cmp(32'(s[2]), 32'h1);
        for (int i = 0; i < 80; i++) begin
            @(posedge clock);
            if (link.divided_ref_line !== 1'b0) hi++;
        end
        cmp(32'(hi), 32'h0);
        wr_reg(srcc_pkg::H_STAT, 32'h0);
        rd_reg(srcc_pkg::H_STAT, s);
        cmp(32'(s[2]), 32'h0);
        send({16'h0000, 4'h1, 4'h3, 3'h0, 1'b1, 2'h0, srcc_pkg::SEL_FUNC});
        cmp(32'(link.diag_mux_output), 32'h1);
        meas(60);
        $display("function test done");
    endtask
    task automatic t_ext();
        wr_reg(srcc_pkg::H_CTRL, 32'h3);
        send({6'h00, 1'b1, 2'h0, 4'h2, 11'h000, 6'h00, srcc_pkg::SEL_REF});
        cmp(32'(xtal_run), 32'h0);
        cmp(32'(link.diag_mux_output), 32'h0);
        meas(12);
        $display("external reference test done");
    endtask
    task automatic t_down();
        wr_reg(srcc_pkg::H_CTRL, 32'h0);
        repeat (10) @(posedge clock);
        cmp({supply_ok, xtal_run, var_trim, vco_bias, div_word}, 32'h04000000);
        wr_reg(srcc_pkg::H_CTRL, 32'h1);
        wr_reg(srcc_pkg::H_TX, {6'h00, 1'b0, 2'h2, 4'h8, 11'h000, 6'h00, srcc_pkg::SEL_REF});
        meas(32);
        cmp(32'(var_trim), 32'h0);
        wait_stat(0, 1'b0, 2300);
        repeat (8) @(posedge clock);
        cmp(32'(var_trim), 32'h2);
        $display("power down test done");
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        t_power();
        t_words();
        t_func();
        t_ext();
        t_down();
        conclude();
    end
endmodule
